// *** src/erc_pkg.sv ***
`default_nettype none
package erc_pkg;
   // request codes
   localparam logic [7:0] CODE_POS     = 8'h02;
   localparam logic [7:0] CODE_ERR_RST = 8'hba;
   localparam logic [7:0] CODE_POS_RST = 8'hc2;
   localparam logic [7:0] CODE_MT_RST  = 8'h62;
   localparam logic [7:0] CODE_RD      = 8'hea;
   localparam logic [7:0] CODE_WR      = 8'h32;
   // timing
   localparam int         CLK_MHZ      = 10;
   localparam int         MIN_GAP_US   = 40;
   localparam logic [8:0] MIN_GAP_CYC  = 9'(MIN_GAP_US * CLK_MHZ);
   localparam int         ERR_BUSY_US  = 2000;
   localparam int         ERR_BUSY_DEF = ERR_BUSY_US * CLK_MHZ;
   localparam int         POS_RST_US   = 18000;
   localparam int         POS_RST_DEF  = POS_RST_US * CLK_MHZ;
   localparam logic [3:0] RST_REPEATS  = 4'ha;
   localparam logic [7:0] NV_WR_CYC    = 8'h40;
   // resolution select
   localparam logic [1:0] RES_23       = 2'h0;
   localparam logic [1:0] RES_21       = 2'h1;
   localparam logic [1:0] RES_17       = 2'h2;
   // field positions and nonvolatile layout
   localparam int         SF_PERIOD_BIT = 4;
   localparam int         SF_ALARM_BIT  = 5;
   localparam logic [6:0] OFF_ST_WORD   = 7'h7d;
   localparam logic [6:0] OFF_MT_WORD   = 7'h7b;
   localparam logic [2:0] RSP_POS_LEN   = 3'h6;
   localparam logic [2:0] RSP_NV_LEN    = 3'h4;
   localparam logic [7:0] CRC_INIT      = 8'h00;

   typedef struct packed {
      logic [7:0] code;
      logic [7:0] adf;
      logic [7:0] edf;
      logic [7:0] crc;
   } erc_req_t;

   typedef struct packed {
      logic sync;
      logic period;
      logic mt_supply;
   } erc_fault_t;

   typedef enum logic [1:0] {
      ERC_IDLE = 2'b01,
      ERC_SEND = 2'b10
   } erc_state_t;

   function automatic logic [7:0] erc_crc_byte(input logic [7:0] c_in,
                                               input logic [7:0] b);
      logic [7:0] c;
      logic       inv;
      c = c_in;
      for (int i = 0; i < 8; i++) begin
         inv = b[i] ^ c[7];
         c   = {c[6:0], inv};
      end
      return c;
   endfunction

   // byte 0 sits in the low bits
   function automatic logic [7:0] erc_crc_seq(input logic [39:0] d,
                                              input int n);
      logic [7:0] c;
      c = CRC_INIT;
      for (int i = 0; i < 5; i++) begin
         if (i < n) begin
            c = erc_crc_byte(c, d[8*i +: 8]);
         end
      end
      return c;
   endfunction
endpackage
`default_nettype wire

// *** src/erc_encoder_cmd.sv ***
`timescale 1ns/100ps
`default_nettype none
module erc_encoder_cmd
   import erc_pkg::*;
#(
   parameter int ERR_BUSY_CYC = ERR_BUSY_DEF,
   parameter int POS_RST_CYC  = POS_RST_DEF
)(
   // clock, reset, enable
   input  wire logic        ref_clk,
   input  wire logic        rst,
   input  wire logic        ce,
   // decoded request frame
   input  wire logic        req_valid,
   input  wire erc_req_t    req,
   // reply byte stream
   input  wire logic        tx_ready,
   output logic             tx_valid,
   output logic [7:0]       tx_byte,
   output logic             tx_last,
   // sensor side
   input  wire logic [23:0] raw_st,
   input  wire logic [15:0] raw_mt,
   input  wire logic        shaft_still,
   input  wire logic [1:0]  res_sel,
   input  wire erc_fault_t  fault_evt,
   // status
   output erc_fault_t       faults,
   output logic             busy,
   output logic             mem_busy,
   output logic [23:0]      st_pos,
   output logic [15:0]      mt_pos
);

   function automatic logic [23:0] erc_mask(input logic [23:0] p,
                                            input logic [1:0]  s);
      case (s)
         RES_21: return {3'h0, p[20:0]};
         RES_17: return {7'h0, p[16:0]};
         default: return {1'b0, p[22:0]};
      endcase
   endfunction

   erc_state_t  state_ff;
   erc_state_t  nxt_state;
   // nonvolatile array keeps its content through reset
   logic [7:0]  mem_ff [128] = '{default: 8'h00};
   logic [47:0] buf_ff;
   logic [47:0] nxt_buf;
   logic [2:0]  left_ff;
   logic [2:0]  nxt_left;
   logic [3:0]  rep_ff;
   logic [3:0]  nxt_rep;
   logic [7:0]  last_code_ff;
   logic [8:0]  gap_ff;
   logic [17:0] busy_cnt_ff;
   logic [17:0] nxt_busy_cnt;
   logic [7:0]  wr_cnt_ff;
   logic [6:0]  wr_addr_ff;
   logic [7:0]  wr_data_ff;
   erc_fault_t  faults_ff;
   logic        busy_ff;
   logic [23:0] st_pos_ff;
   logic [15:0] mt_pos_ff;
   logic [17:0] busy_run_ff;
   logic        err_mode_ff;

   wire         idle     = (state_ff == ERC_IDLE);
   wire         is_rd    = (req.code == CODE_RD);
   wire         is_wr    = (req.code == CODE_WR);
   wire         is_rst   = (req.code == CODE_ERR_RST) ||
                           (req.code == CODE_POS_RST) ||
                           (req.code == CODE_MT_RST);
   wire         is_pos   = is_rst || (req.code == CODE_POS);
   wire         known    = is_pos || is_rd || is_wr;
   wire [39:0]  rx_body  = {16'h0, req.edf, req.adf, req.code};
   wire [7:0]   rx_crc   = erc_crc_seq(rx_body, is_wr ? 3 : 2);
   wire         crc_ok   = !(is_rd || is_wr) || (rx_crc == req.crc);
   wire         take_raw = ce && req_valid && idle && known;
   wire         take     = take_raw && crc_ok;
   wire         pend     = (wr_cnt_ff != 8'h0);

   wire         same_rst = is_rst && (req.code == last_code_ff) &&
                           (gap_ff >= MIN_GAP_CYC) && (rep_ff != 4'h0);
   assign nxt_rep = same_rst ? 4'(rep_ff + 4'h1) : {3'h0, is_rst};
   wire         fire     = take && is_rst && (nxt_rep == RST_REPEATS);
   wire         fire_err = fire && (req.code != CODE_POS_RST);
   wire         fire_mt  = fire && (req.code == CODE_MT_RST);
   // position reset only with shaft at rest
   wire         fire_pos = fire && (req.code == CODE_POS_RST) &&
                           shaft_still;
   // no new write while one is pending
   wire         wr_acc   = take && is_wr && !pend;

   // zero point read back from stored words
   wire [23:0]  st_off   = {mem_ff[OFF_ST_WORD + 7'h2],
                            mem_ff[OFF_ST_WORD + 7'h1],
                            mem_ff[OFF_ST_WORD]};
   wire [15:0]  mt_off   = {mem_ff[OFF_MT_WORD + 7'h1],
                            mem_ff[OFF_MT_WORD]};
   wire [23:0]  st_rel   = 24'(raw_st - st_off);
   wire [15:0]  mt_rel   = 16'(raw_mt - mt_off);

   wire [7:0]   sf;
   assign sf[3:0]            = 4'h0;
   assign sf[SF_PERIOD_BIT]  = faults_ff.period;
   assign sf[SF_ALARM_BIT]   = busy_ff || faults_ff.sync ||
                               faults_ff.mt_supply;
   assign sf[7:6]            = 2'h0;

   wire [39:0]  pos_body = {st_pos_ff[23:16], st_pos_ff[15:8],
                            st_pos_ff[7:0], sf, req.code};
   // word address above, pending flag in bit 0
   // incoming bit 0 is never used as address
   wire [7:0]   adf_o    = {req.adf[7:1], pend};
   // read during write gives zero data
   wire [7:0]   rd_data  = pend ? 8'h00 : mem_ff[req.adf[7:1]];
   wire [7:0]   nv_data  = is_rd ? rd_data : req.edf;
   wire [39:0]  nv_body  = {16'h0, nv_data, adf_o, req.code};
   wire [7:0]   pos_crc  = erc_crc_seq(pos_body, 5);
   wire [7:0]   nv_crc   = erc_crc_seq(nv_body, 3);

   // reply is latched whole, so later status changes do not tear it
   always_comb begin
      nxt_state = state_ff;
      nxt_buf   = buf_ff;
      nxt_left  = left_ff;
      case (state_ff)
         ERC_IDLE: begin
            if (take && is_pos) begin
               nxt_buf   = {pos_crc, pos_body};
               nxt_left  = RSP_POS_LEN;
               nxt_state = ERC_SEND;
            end else if (take) begin
               nxt_buf   = {16'h0, nv_crc, nv_body[23:0]};
               nxt_left  = RSP_NV_LEN;
               nxt_state = ERC_SEND;
            end
         end
         ERC_SEND: begin
            if (tx_ready) begin
               nxt_buf  = {8'h0, buf_ff[47:8]};
               nxt_left = 3'(left_ff - 3'h1);
               if (left_ff == 3'h1) begin
                  nxt_state = ERC_IDLE;
               end
            end
         end
         default: begin
            nxt_state = ERC_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state_ff <= ERC_IDLE;
         buf_ff   <= 48'h0;
         left_ff  <= 3'h0;
      end else if (ce) begin
         state_ff <= nxt_state;
         buf_ff   <= nxt_buf;
         left_ff  <= nxt_left;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rep_ff       <= 4'h0;
         last_code_ff <= 8'h00;
         gap_ff       <= MIN_GAP_CYC;
      end else if (ce) begin
         if (take) begin
            rep_ff       <= fire ? 4'h0 : nxt_rep;
            last_code_ff <= req.code;
            gap_ff       <= 9'h0;
         end else if (gap_ff < MIN_GAP_CYC) begin
            gap_ff <= 9'(gap_ff + 9'h1);
         end
      end
   end

   always_comb begin
      if (fire_pos) begin
         nxt_busy_cnt = 18'(POS_RST_CYC);
      end else if (fire_err) begin
         nxt_busy_cnt = 18'(ERR_BUSY_CYC);
      end else if (busy_cnt_ff != 18'h0) begin
         nxt_busy_cnt = 18'(busy_cnt_ff - 18'h1);
      end else begin
         nxt_busy_cnt = 18'h0;
      end
   end

   wire nxt_busy = (nxt_busy_cnt != 18'h0);

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         busy_cnt_ff <= 18'h0;
         busy_ff     <= 1'b0;
      end else if (ce) begin
         busy_cnt_ff <= nxt_busy_cnt;
         busy_ff     <= nxt_busy;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         st_pos_ff <= 24'h0;
         mt_pos_ff <= 16'h0;
      end else if (ce) begin
         st_pos_ff <= nxt_busy ? 24'h0 : erc_mask(st_rel, res_sel);
         mt_pos_ff <= nxt_busy ? 16'h0 : mt_rel;
      end
   end

   // clear all latches on error reset or turn reset
   // new events win over the clear
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         faults_ff <= '0;
      end else if (ce) begin
         faults_ff <= (fire_err ? erc_fault_t'(3'h0) : faults_ff) |
                      fault_evt;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         wr_cnt_ff  <= 8'h0;
         wr_addr_ff <= 7'h0;
         wr_data_ff <= 8'h00;
      end else if (ce) begin
         if (wr_acc) begin
            wr_cnt_ff  <= NV_WR_CYC;
            wr_addr_ff <= req.adf[7:1];
            wr_data_ff <= req.edf;
         end else if (pend) begin
            wr_cnt_ff <= 8'(wr_cnt_ff - 8'h1);
         end
      end
   end

   // store new zero point in nonvolatile words
   always_ff @(posedge ref_clk) begin
      if (ce) begin
         if (wr_cnt_ff == 8'h1) begin
            mem_ff[wr_addr_ff] <= wr_data_ff;
         end
         if (fire_pos) begin
            mem_ff[OFF_ST_WORD]        <= raw_st[7:0];
            mem_ff[OFF_ST_WORD + 7'h1] <= raw_st[15:8];
            mem_ff[OFF_ST_WORD + 7'h2] <= raw_st[23:16];
         end
         if (fire_pos || fire_mt) begin
            mem_ff[OFF_MT_WORD]        <= raw_mt[7:0];
            mem_ff[OFF_MT_WORD + 7'h1] <= raw_mt[15:8];
         end
      end
   end

   // helper: length of the current busy stretch
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         busy_run_ff <= 18'h0;
         err_mode_ff <= 1'b0;
      end else if (ce) begin
         if (fire) begin
            busy_run_ff <= 18'h1;
            err_mode_ff <= !fire_pos;
         end else if (nxt_busy) begin
            busy_run_ff <= 18'(busy_run_ff + 18'h1);
         end else begin
            busy_run_ff <= 18'h0;
         end
      end
   end

   assign tx_valid = (state_ff == ERC_SEND);
   assign tx_byte  = buf_ff[7:0];
   assign tx_last  = tx_valid && (left_ff == 3'h1);
   assign faults   = faults_ff;
   assign busy     = busy_ff;
   assign mem_busy = pend;
   assign st_pos   = st_pos_ff;
   assign mt_pos   = mt_pos_ff;

   a_crc_drop: assert property (
      @(posedge ref_clk) disable iff (rst)
      (take_raw && !crc_ok) |=> (state_ff == ERC_IDLE))
      else $error("bad check byte was answered");

   a_err_busy_len: assert property (
      @(posedge ref_clk) disable iff (rst)
      (err_mode_ff && busy_ff) |-> (busy_run_ff <= 18'(ERR_BUSY_CYC)))
      else $error("error reset busy too long");

   a_pos_busy_len: assert property (
      @(posedge ref_clk) disable iff (rst)
      busy_ff |-> (busy_run_ff <= 18'(POS_RST_CYC)))
      else $error("position reset busy too long");

   a_pos_zero: assert property (
      @(posedge ref_clk) disable iff (rst)
      fire_pos |=> (st_off == $past(raw_st)) && (mt_off == $past(raw_mt)))
      else $error("position reset did not zero counts");

   a_mt_clear: assert property (
      @(posedge ref_clk) disable iff (rst)
      (fire_mt && (fault_evt == 3'h0)) |=>
         (faults_ff == 3'h0) && $stable(st_off) && busy_ff)
      else $error("turn reset wrong");

   a_err_keep: assert property (
      @(posedge ref_clk) disable iff (rst)
      (fire_err && !fire_mt) |=> $stable(st_off) && $stable(mt_off))
      else $error("errors reset touched position");

   a_rd_pend: assert property (
      @(posedge ref_clk) disable iff (rst)
      (take && is_rd && pend) |=>
         buf_ff[8] && (buf_ff[23:16] == 8'h00) && (left_ff == RSP_NV_LEN))
      else $error("read during write answered wrongly");

   a_wr_ignore: assert property (
      @(posedge ref_clk) disable iff (rst)
      (take && is_wr && pend) |=> $stable(wr_addr_ff) && $stable(wr_data_ff))
      else $error("write during write was taken");

   a_res_mask: assert property (
      @(posedge ref_clk) disable iff (rst)
      ($past(ce) && ($past(res_sel) == RES_17)) |-> (st_pos_ff[23:17] == 7'h0))
      else $error("bits above resolution set");

   a_rep_restart: assert property (
      @(posedge ref_clk) disable iff (rst)
      (take && is_rst && (gap_ff < MIN_GAP_CYC)) |=> (rep_ff == 4'h1))
      else $error("repeat count not restarted");

   a_pos_reply: assert property (
      @(posedge ref_clk) disable iff (rst)
      (take && (req.code == CODE_POS)) |=>
         tx_valid && (left_ff == RSP_POS_LEN) && (tx_byte == CODE_POS))
      else $error("position reply malformed");

endmodule
`default_nettype wire

// *** test/erc_master_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module erc_master_model
   import erc_pkg::*;
(
   // clock and pacing
   input  wire logic       ref_clk,
   input  wire logic       stall,
   // request side
   output logic            req_valid,
   output erc_req_t        req,
   // reply side
   output logic            tx_ready,
   input  wire logic       tx_valid,
   input  wire logic [7:0] tx_byte,
   input  wire logic       tx_last
);
   logic ph;

   initial begin
      req_valid = 1'b0;
      req = '0;
      tx_ready = 1'b0;
      ph = 1'b0;
   end

   // ready toggles while stalling, so bytes must be held
   always @(negedge ref_clk) begin
      ph <= ~ph;
      tx_ready <= ~stall | ph;
   end

   function automatic logic [7:0] crc8(input logic [47:0] d, input int n);
      logic [7:0] c;
      c = 8'h00;
      for (int k = 0; k < 8 * n; k++) begin
         c = {c[6:0], d[k] ^ c[7]};
      end
      return c;
   endfunction

   task automatic transact(input logic [7:0] code, input logic [6:0] addr,
                           input logic [7:0] data, input logic good,
                           output logic [47:0] rep, output int n);
      logic [7:0] adf;
      logic [7:0] chk;
      // word address high, pending bit sent as zero
      adf = {addr, 1'b0};
      chk = crc8({24'h0, data, adf, code}, (code == CODE_WR) ? 3 : 2);
      rep = '0;
      n = 0;
      @(negedge ref_clk);
      req_valid = 1'b1;
      req = '{code, adf, data, good ? chk : ~chk};
      @(negedge ref_clk);
      req_valid = 1'b0;
      // bounded wait: a silent device simply yields no bytes
      for (int t = 0; t < 40; t++) begin
         @(posedge ref_clk);
         if (tx_valid && tx_ready && n < 6) begin
            rep[8*n +: 8] = tx_byte;
            n++;
            if (tx_last) begin
               break;
            end
         end
      end
   endtask

   // same code repeated, spaced, shaft at rest
   task automatic reset_seq(input logic [7:0] code, input int cnt,
                            input int gap);
      logic [47:0] r;
      int          n;
      for (int i = 0; i < cnt; i++) begin
         repeat (gap - 6) @(posedge ref_clk);
         transact(code, 7'h00, 8'h00, 1'b1, r, n);
      end
   endtask
endmodule
`default_nettype wire

// *** test/tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_top
   import erc_pkg::*;
;
   typedef struct packed {
      logic [1:0]  res;
      logic        stall;
      logic [23:0] raw;
      logic [23:0] pos;
   } erc_row_t;

   localparam erc_row_t ROWS [5] = '{
      '{2'h0, 1'b0, 24'hffffff, 24'h7fffff},
      '{2'h1, 1'b1, 24'hffffff, 24'h1fffff},
      '{2'h2, 1'b0, 24'hffffff, 24'h01ffff},
      '{2'h3, 1'b1, 24'h9abcde, 24'h1abcde},
      '{2'h2, 1'b0, 24'h0a5a5a, 24'h005a5a}};

   logic        ref_clk;
   logic        rst;
   logic        ce;
   logic        stall;
   logic        req_valid;
   erc_req_t    req;
   logic        tx_ready;
   logic        tx_valid;
   logic [7:0]  tx_byte;
   logic        tx_last;
   logic [23:0] raw_st;
   logic [15:0] raw_mt;
   logic        shaft_still;
   logic [1:0]  res_sel;
   erc_fault_t  fault_evt;
   erc_fault_t  faults;
   logic        busy;
   logic        mem_busy;
   logic [23:0] st_pos;
   logic [15:0] mt_pos;
   logic [47:0] rep;
   logic [47:0] exp48;
   int          nrep;
   int          n_errors;
   int          checked;
   int          busy_cnt;

   // short busy counts keep the run brief
   erc_encoder_cmd #(.ERR_BUSY_CYC(20), .POS_RST_CYC(50)) erc_encoder_cmd_i (
      .ref_clk(ref_clk), .rst(rst), .ce(ce), .req_valid(req_valid),
      .req(req), .tx_ready(tx_ready), .tx_valid(tx_valid),
      .tx_byte(tx_byte), .tx_last(tx_last), .raw_st(raw_st),
      .raw_mt(raw_mt), .shaft_still(shaft_still), .res_sel(res_sel),
      .fault_evt(fault_evt), .faults(faults), .busy(busy),
      .mem_busy(mem_busy), .st_pos(st_pos), .mt_pos(mt_pos));

   erc_master_model erc_master_model_i (
      .ref_clk(ref_clk), .stall(stall), .req_valid(req_valid), .req(req),
      .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_byte(tx_byte),
      .tx_last(tx_last));

   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   always @(posedge ref_clk) begin
      if (busy === 1'b1) begin
         busy_cnt <= busy_cnt + 1;
      end
   end

   task automatic summarize;
      if (n_errors == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic cmp_val(input logic [23:0] g, input logic [23:0] e);
      checked++;
      if (g !== e) begin
         n_errors++;
         $display("BAD %0t value %h want %h", $time, g, e);
      end
   endtask

   task automatic check_reply(input logic [47:0] e, input int nb);
      logic [47:0] x;
      x = e;
      if (nb > 0) begin
         x[8*(nb-1) +: 8] = erc_master_model_i.crc8(e, nb - 1);
      end
      checked++;
      if (nrep !== nb || rep !== x) begin
         n_errors++;
         $display("BAD %0t reply %h/%0d want %h/%0d", $time, rep, nrep, x, nb);
      end
   endtask

   task automatic xfer(input logic [7:0] c, input logic [6:0] a,
                       input logic [7:0] d, input logic g);
      erc_master_model_i.transact(c, a, d, g, rep, nrep);
   endtask

   task automatic pulse(input logic [2:0] f);
      @(negedge ref_clk);
      fault_evt = f;
      @(negedge ref_clk);
      fault_evt = '0;
   endtask

   task automatic busy_len(input int len);
      repeat (80) @(negedge ref_clk);
      cmp_val(24'(busy_cnt), 24'(len));
   endtask

   initial begin
      repeat (95000) @(posedge ref_clk);
      n_errors++;
      summarize;
   end

   initial begin
      rst = 1'b1;
      ce = 1'b1;
      stall = 1'b0;
      raw_st = '0;
      raw_mt = 16'h0055;
      shaft_still = 1'b1;
      res_sel = 2'h0;
      fault_evt = '0;
      n_errors = 0;
      checked = 0;
      busy_cnt = 0;
      repeat (2) @(negedge ref_clk);
      rst = 1'b0;
      cmp_val({20'h0, tx_valid, busy, mem_busy, tx_last}, 24'h0);
      cmp_val({21'h0, faults}, 24'h0);
      for (int i = 0; i < 5; i++) begin
         @(negedge ref_clk);
         res_sel = ROWS[i].res;
         stall = ROWS[i].stall;
         raw_st = ROWS[i].raw;
         xfer(CODE_POS, 7'h00, 8'h00, 1'b1);
         exp48 = {8'h0, ROWS[i].pos, 8'h0, CODE_POS};
         check_reply(exp48, 6);
         cmp_val(st_pos, ROWS[i].pos);
      end
      // pending write: second write and read are turned away
      xfer(CODE_WR, 7'h10, 8'ha5, 1'b1);
      check_reply({24'h0, 8'ha5, 8'h20, CODE_WR}, 4);
      xfer(CODE_WR, 7'h10, 8'h3c, 1'b1);
      check_reply({24'h0, 8'h3c, 8'h21, CODE_WR}, 4);
      xfer(CODE_RD, 7'h10, 8'h00, 1'b1);
      check_reply({24'h0, 8'h00, 8'h21, CODE_RD}, 4);
      repeat (70) @(negedge ref_clk);
      xfer(CODE_RD, 7'h10, 8'h00, 1'b0);
      check_reply(48'h0, 0);
      xfer(CODE_RD, 7'h10, 8'h00, 1'b1);
      check_reply({24'h0, 8'ha5, 8'h20, CODE_RD}, 4);
      // latched faults, short gap restarts the count
      @(negedge ref_clk);
      res_sel = 2'h0;
      raw_st = 24'h012345;
      pulse(3'b110);
      xfer(CODE_POS, 7'h00, 8'h00, 1'b1);
      exp48 = {8'h0, 24'h012345, 8'h30, CODE_POS};
      check_reply(exp48, 6);
      erc_master_model_i.reset_seq(CODE_ERR_RST, 9, 400);
      erc_master_model_i.reset_seq(CODE_ERR_RST, 1, 100);
      cmp_val({21'h0, faults}, 24'h6);
      busy_cnt = 0;
      erc_master_model_i.reset_seq(CODE_ERR_RST, 9, 400);
      cmp_val({21'h0, faults}, 24'h0);
      xfer(CODE_POS, 7'h00, 8'h00, 1'b1);
      exp48 = {8'h0, 24'h0, 8'h20, CODE_POS};
      check_reply(exp48, 6);
      busy_len(20);
      cmp_val(st_pos, 24'h012345);
      pulse(3'b001);
      cmp_val({8'h0, mt_pos}, 24'h55);
      busy_cnt = 0;
      erc_master_model_i.reset_seq(CODE_MT_RST, 10, 400);
      cmp_val({21'h0, faults}, 24'h0);
      busy_len(20);
      cmp_val({8'h0, mt_pos}, 24'h0);
      cmp_val(st_pos, 24'h012345);
      busy_cnt = 0;
      erc_master_model_i.reset_seq(CODE_POS_RST, 10, 400);
      busy_len(50);
      cmp_val(st_pos, 24'h0);
      cmp_val({8'h0, mt_pos}, 24'h0);
      // zero point must stick once stored
      raw_st = 24'h012349;
      repeat (3) @(negedge ref_clk);
      cmp_val(st_pos, 24'h4);
      // enable low must freeze the corrected position
      ce = 1'b0;
      raw_st = 24'h012350;
      repeat (3) @(negedge ref_clk);
      cmp_val(st_pos, 24'h4);
      ce = 1'b1;
      repeat (3) @(negedge ref_clk);
      cmp_val(st_pos, 24'hb);
      summarize;
   end
endmodule
`default_nettype wire
